//--- src/pigpc_pkg.sv
/*
  pigpc_pkg: constants shared by the programmable-logic input gating and
  power control block. Assumes a 40 MHz core clock.
*/
package pigpc_pkg;

  // register offsets within the control-register window, and the power-register reset value
  localparam logic [7:0] PIGPC_OFS_CTRL_A = 8'hb0;
  localparam logic [7:0] PIGPC_OFS_BLOCK_B = 8'hb4;
  localparam logic [7:0] PIGPC_PM_RESET = 8'h00;

  // power_mgmt_ctrl_a fields
  localparam int PIGPC_A_TURBO_OFF = 3;
  localparam int PIGPC_A_CLK_BUS_BLK = 4;
  localparam int PIGPC_A_CLK_OMC_BLK = 5;

  // power_mgmt_block_b fields
  localparam int PIGPC_B_RD_BLK = 2;
  localparam int PIGPC_B_WR_BLK = 3;
  localparam int PIGPC_B_PROGRAM_FETCH_STROBE_BLK = 4;
  localparam int PIGPC_B_ALE_BLK = 5;
  localparam int PIGPC_B_PC7_BLK = 6;

  // logic input bus lane positions
  localparam int PIGPC_L_RD = 0;
  localparam int PIGPC_L_WR = 1;
  localparam int PIGPC_L_PROGRAM_FETCH_STROBE = 2;
  localparam int PIGPC_L_ALE = 3;
  localparam int PIGPC_L_PC7 = 4;
  localparam int PIGPC_L_CLK = 5;
  localparam int PIGPC_LBUS_W = 6;

  // select lane positions
  localparam int PIGPC_S_MAIN = 0;
  localparam int PIGPC_S_BOOT = 1;
  localparam int PIGPC_S_SRAM = 2;
  localparam int PIGPC_S_CREG = 3;
  localparam int PIGPC_SEL_W = 4;

  // quiet time before standby, and cycle counts derived from it
  localparam int PIGPC_CLK_PERIOD_PS = 25000;
  localparam int PIGPC_QUIET_5V_NS = 65;
  localparam int PIGPC_QUIET_3V3_NS = 100;
  localparam int PIGPC_QUIET_5V_CYC = (PIGPC_QUIET_5V_NS * 1000 + PIGPC_CLK_PERIOD_PS - 1) / PIGPC_CLK_PERIOD_PS;
  localparam int PIGPC_QUIET_3V3_CYC = (PIGPC_QUIET_3V3_NS * 1000 + PIGPC_CLK_PERIOD_PS - 1) / PIGPC_CLK_PERIOD_PS;
  localparam int PIGPC_IDLE_W = 4;

endpackage : pigpc_pkg

//--- src/pigpc_top.sv
/*
  pigpc_top: chip-select input gating, non-turbo standby, and blocking of
  bus strobes, port input and common clock from the logic input bus.
  Assumes bus strobes, warm reset, config and register port are on clock;
  the pins port_d_bit_two, port_c_bit_seven and common_clock_in are not.
*/
`timescale 1ns/1ps
module pigpc_top #(
  parameter int LBUS_W = pigpc_pkg::PIGPC_LBUS_W,
  parameter int SEL_W = pigpc_pkg::PIGPC_SEL_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic warm_reset_n,
  input wire logic cfg_csi_enable,
  input wire logic cfg_common_clock_in_enable,
  input wire logic cfg_five_volt,
  input wire logic port_d_bit_two,
  input wire logic port_c_bit_seven,
  input wire logic common_clock_in,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic program_fetch_strobe,
  input wire logic ale,
  input wire logic [SEL_W-1:0] decode_hit,
  input wire logic reg_sel,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [SEL_W-1:0] mem_select,
  output logic [3:0] mem_strobe,
  output logic [LBUS_W-1:0] logic_input_bus,
  output logic logic_standby,
  output logic common_clock_in_to_macrocell,
  output logic common_clock_in_to_apd,
  output logic power_down_wake
);
  import pigpc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] block_b;
    logic [1:0] csi_sync;
    logic [1:0] pc7_sync;
    logic [1:0] clk_sync;
    logic csi_prev;
    logic cfg_done;
    logic cfg_csi;
    logic cfg_clk;
    logic cfg_five;
    logic [LBUS_W-1:0] raw_prev;
    logic [PIGPC_IDLE_W-1:0] idle_cnt;
    logic standby;
    logic [LBUS_W-1:0] lbus;
    logic [SEL_W-1:0] sel_stage;
    logic [SEL_W-1:0] sel;
    logic [3:0] strobe;
    logic clk_omc;
    logic clk_apd;
    logic wake;
    logic [7:0] rdata;
  } pigpc_state_s;

  pigpc_state_s st_r;
  pigpc_state_s st_nxt;

  logic [LBUS_W-1:0] raw_bus;
  logic [LBUS_W-1:0] blk_mask;
  logic csi_active;
  logic turbo_off;
  logic quiet_done;
  logic [PIGPC_IDLE_W-1:0] quiet_cyc;

  // read mux for the two power registers, zero elsewhere
  function automatic logic [7:0] pigpc_read(input logic [7:0] addr, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    if (addr == PIGPC_OFS_CTRL_A)
    begin
      v = a;
    end
    else if (addr == PIGPC_OFS_BLOCK_B)
    begin
      v = b;
    end
    return v;
  endfunction : pigpc_read

  always_comb
  begin
    turbo_off = st_r.ctrl_a[PIGPC_A_TURBO_OFF];
    // unconfigured pin behaves as asserted select
    csi_active = st_r.cfg_csi ? ~st_r.csi_sync[1] : 1'b1;
    quiet_cyc = st_r.cfg_five ? PIGPC_IDLE_W'(PIGPC_QUIET_5V_CYC) : PIGPC_IDLE_W'(PIGPC_QUIET_3V3_CYC);

    // raw inputs toward the logic input bus
    raw_bus = '0;
    raw_bus[PIGPC_L_RD] = rd_n;
    raw_bus[PIGPC_L_WR] = wr_n;
    raw_bus[PIGPC_L_PROGRAM_FETCH_STROBE] = program_fetch_strobe;
    raw_bus[PIGPC_L_ALE] = ale;
    raw_bus[PIGPC_L_PC7] = st_r.pc7_sync[1];
    raw_bus[PIGPC_L_CLK] = st_r.clk_sync[1] & st_r.cfg_clk;

    blk_mask = '1;
    blk_mask[PIGPC_L_RD] = ~st_r.block_b[PIGPC_B_RD_BLK];
    blk_mask[PIGPC_L_WR] = ~st_r.block_b[PIGPC_B_WR_BLK];
    blk_mask[PIGPC_L_PROGRAM_FETCH_STROBE] = ~st_r.block_b[PIGPC_B_PROGRAM_FETCH_STROBE_BLK];
    blk_mask[PIGPC_L_ALE] = ~st_r.block_b[PIGPC_B_ALE_BLK];
    blk_mask[PIGPC_L_PC7] = ~st_r.block_b[PIGPC_B_PC7_BLK];
    blk_mask[PIGPC_L_CLK] = ~st_r.ctrl_a[PIGPC_A_CLK_BUS_BLK];
    raw_bus = raw_bus & blk_mask;

    quiet_done = (st_r.idle_cnt >= quiet_cyc);

    st_nxt = st_r;
    st_nxt.csi_sync = {st_r.csi_sync[0], port_d_bit_two};
    st_nxt.pc7_sync = {st_r.pc7_sync[0], port_c_bit_seven};
    st_nxt.clk_sync = {st_r.clk_sync[0], common_clock_in};

    // configuration caught once after power-up release
    if (!st_r.cfg_done)
    begin
      st_nxt.cfg_done = 1'b1;
      st_nxt.cfg_csi = cfg_csi_enable;
      st_nxt.cfg_clk = cfg_common_clock_in_enable;
      st_nxt.cfg_five = cfg_five_volt;
    end

    // power registers survive warm reset
    if (reg_sel && reg_wr && reg_addr == PIGPC_OFS_CTRL_A)
    begin
      st_nxt.ctrl_a = reg_wdata;
    end
    if (reg_sel && reg_wr && reg_addr == PIGPC_OFS_BLOCK_B)
    begin
      st_nxt.block_b = reg_wdata;
    end
    st_nxt.rdata = reg_sel ? pigpc_read(reg_addr, st_r.ctrl_a, st_r.block_b) : 8'h00;

    // standby: any edge on unblocked inputs wakes, quiet time enters
    st_nxt.raw_prev = raw_bus;
    if (!turbo_off || raw_bus != st_r.raw_prev)
    begin
      st_nxt.idle_cnt = '0;
      st_nxt.standby = 1'b0;
    end
    else if (quiet_done)
    begin
      st_nxt.standby = 1'b1;
    end
    else
    begin
      st_nxt.idle_cnt = st_r.idle_cnt + PIGPC_IDLE_W'(1);
    end

    // logic bus follows inputs, frozen while in standby; select pin has no say
    if (!st_nxt.standby)
    begin
      st_nxt.lbus = raw_bus;
    end

    // memory selects gated by chip select; extra stage when turbo is off
    st_nxt.sel_stage = decode_hit & {SEL_W{csi_active}};
    if (!csi_active)
    begin
      st_nxt.sel = '0;
    end
    else if (turbo_off)
    begin
      st_nxt.sel = st_r.sel_stage;
    end
    else
    begin
      st_nxt.sel = st_nxt.sel_stage;
    end

    // strobes go to memories regardless of blocking bits
    st_nxt.strobe = {ale, program_fetch_strobe, wr_n, rd_n};

    st_nxt.clk_omc = st_r.clk_sync[1] & st_r.cfg_clk & ~st_r.ctrl_a[PIGPC_A_CLK_OMC_BLK];
    st_nxt.clk_apd = st_r.clk_sync[1] & st_r.cfg_clk;

    st_nxt.csi_prev = st_r.csi_sync[1];
    st_nxt.wake = st_r.cfg_csi & st_r.csi_prev & ~st_r.csi_sync[1];

    // warm reset clears idle count, standby, selects, wake and read data but not the power registers
    if (!warm_reset_n)
    begin
      st_nxt.idle_cnt = '0;
      st_nxt.standby = 1'b0;
      st_nxt.sel_stage = '0;
      st_nxt.sel = '0;
      st_nxt.wake = 1'b0;
      st_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.ctrl_a <= PIGPC_PM_RESET;
      st_r.block_b <= PIGPC_PM_RESET;
      st_r.csi_sync <= 2'h3;
      st_r.csi_prev <= 1'b1;
      st_r.raw_prev <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign mem_select = st_r.sel;
  assign mem_strobe = st_r.strobe;
  assign logic_input_bus = st_r.lbus;
  assign logic_standby = st_r.standby;
  assign common_clock_in_to_macrocell = st_r.clk_omc;
  assign common_clock_in_to_apd = st_r.clk_apd;
  assign power_down_wake = st_r.wake;

endmodule : pigpc_top

//--- tb/pigpc_partner.sv
/* far side: external chip-select driver and common clock source; runs on the core clock */
`timescale 1ns/1ps
module pigpc_partner (
  input wire logic clock,
  input wire logic cs_on,
  input wire logic clk_run,
  output logic port_d_bit_two,
  output logic common_clock_in
);
  logic [1:0] div_r = 2'h0;
  // clock stands still low outside bursts
  always @(posedge clock)
    div_r <= #1 clk_run ? div_r + 2'h1 : 2'h0;
  assign common_clock_in = div_r[1];
  assign port_d_bit_two = !cs_on;
endmodule : pigpc_partner

//--- tb/pigpc_assertions.sv
/* port checker for pigpc_top; config pins steady between resets */
`timescale 1ns/1ps
module pigpc_assertions (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic warm_reset_n,
  input wire logic cfg_csi_enable,
  input wire logic cfg_common_clock_in_enable,
  input wire logic port_d_bit_two,
  input wire logic common_clock_in,
  input wire logic [3:0] decode_hit,
  input wire logic [3:0] mem_select,
  input wire logic [5:0] logic_input_bus,
  input wire logic logic_standby,
  input wire logic common_clock_in_to_apd,
  input wire logic power_down_wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_cs_off; (cfg_csi_enable && port_d_bit_two) [*6] |=> mem_select == 4'h0;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("select while high");
  property p_cs_on; ((!port_d_bit_two || !cfg_csi_enable) && warm_reset_n && $stable(decode_hit)) [*8]
    |-> mem_select == decode_hit;
  endproperty
  a_cs_on: assert property (p_cs_on) else $error("select lost");
  property p_wake; cfg_csi_enable && $fell(port_d_bit_two) |-> ##[1:5] power_down_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_wake_one; power_down_wake |=> !power_down_wake;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("long wake");
  property p_no_wake; !cfg_csi_enable |-> !power_down_wake;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake unconfigured");
  property p_cnt_clk; cfg_common_clock_in_enable && $rose(common_clock_in) |-> ##[1:5] common_clock_in_to_apd;
  endproperty
  a_cnt_clk: assert property (p_cnt_clk) else $error("counter clock lost");
  property p_freeze; logic_standby ##1 logic_standby |-> $stable(logic_input_bus);
  endproperty
  a_freeze: assert property (p_freeze) else $error("bus moved in standby");
  property p_quiet; $rose(logic_standby) |-> logic_input_bus == $past(logic_input_bus, 2);
  endproperty
  a_quiet: assert property (p_quiet) else $error("standby while busy");
endmodule : pigpc_assertions
bind pigpc_top pigpc_assertions u_chk (.*);

//--- tb/pigpc_top_tb_top.sv
/* bench for pigpc_top; inputs move 1 ns after rising edges */
`timescale 1ns/1ps
module pigpc_top_tb_top;
  import pigpc_pkg::*;
  logic clock = '0, reset_n = '0, warm_reset_n = '1, cfg_csi_enable = '1, cfg_common_clock_in_enable = '1;
  logic cfg_five_volt = '1, port_c_bit_seven = '0, cs_on = '1, clk_run = '0, reg_sel = '0, reg_wr = '0;
  logic [3:0] stb = 4'h7, decode_hit = 4'hf, mem_select, mem_strobe;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [5:0] logic_input_bus;
  logic logic_standby, common_clock_in_to_macrocell, common_clock_in_to_apd, power_down_wake, port_d_bit_two, common_clock_in;
  logic [4:0] seen;
  int n_mismatch = 0, compares = 0, cycles = 0;
  always #12.5 clock = ~clock;
  pigpc_partner u_far (.*);
  pigpc_top uut (.rd_n(stb[0]), .wr_n(stb[1]), .program_fetch_strobe(stb[2]), .ale(stb[3]), .*);
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // one register access; a read compares its data
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    reg_sel = '1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_sel = '0;
    reg_wr = '0;
    if (!w)
      chk(reg_rdata, d);
  endtask : acc
  // collect which outputs showed activity
  task automatic watch(input int n);
    seen = 5'h0;
    repeat (n)
    begin
      cyc(1);
      seen = seen | {logic_input_bus[PIGPC_L_CLK], common_clock_in_to_macrocell, common_clock_in_to_apd, power_down_wake, !logic_standby};
    end
  endtask : watch
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  initial
  begin
    cyc(10);
    reset_n = '1;
    cyc(8);
    acc(PIGPC_OFS_CTRL_A, '0, 8'h00);
    acc(PIGPC_OFS_BLOCK_B, '0, 8'h00);
    acc(8'h10, '1, 8'hff);
    acc(8'h10, '0, 8'h00);
    chk(8'(mem_select), 8'h0f);
    cs_on = '0;
    cyc(8);
    chk(8'(mem_select), 8'h00);
    cs_on = '1;
    watch(6);
    chk(8'(seen[1]), 8'h01);
    acc(PIGPC_OFS_CTRL_A, '1, 8'h08);
    // one access per cycle stands in for the added wait state
    acc(PIGPC_OFS_CTRL_A, '0, 8'h08);
    cyc(4);
    decode_hit = 4'h5;
    cyc(1);
    chk(8'(mem_select), 8'h0f);
    cyc(1);
    chk(8'(mem_select), 8'h05);
    decode_hit = 4'hf;
    $display("selects and registers done");
    for (int b = 0; b < 2; b++)
    begin
      acc(PIGPC_OFS_BLOCK_B, '1, b ? 8'h7c : 8'h00);
      for (int i = 0; i < 5; i++)
      begin
        cyc(8);
        chk(8'(logic_standby), 8'h01);
        if (i < 4)
          stb[i] = ~stb[i];
        else
          port_c_bit_seven = ~port_c_bit_seven;
        watch(6);
        chk(8'(seen[0]), 8'(!b));
        chk(8'(mem_strobe), 8'(stb));
      end
    end
    $display("standby and blocking done");
    for (int k = 0; k < 3; k++)
    begin
      acc(PIGPC_OFS_CTRL_A, '1, 8'(k * 16));
      clk_run = '1;
      watch(12);
      clk_run = '0;
      chk(8'(seen[4:2]), 8'({k != 1, k != 2, 1'b1}));
    end
    $display("clock gating done");
    acc(PIGPC_OFS_CTRL_A, '1, 8'h28);
    warm_reset_n = '0;
    cyc(2);
    warm_reset_n = '1;
    acc(PIGPC_OFS_CTRL_A, '0, 8'h28);
    acc(PIGPC_OFS_BLOCK_B, '0, 8'h7c);
    reset_n = '0;
    cfg_csi_enable = '0;
    cs_on = '0;
    decode_hit = 4'hb;
    cyc(2);
    reset_n = '1;
    cyc(8);
    acc(PIGPC_OFS_CTRL_A, '0, 8'h00);
    chk(8'(mem_select), 8'h0b);
    $display("resets done");
    test_done();
  end
endmodule : pigpc_top_tb_top
